// ==== rtc_pkg.sv ====
// constants shared by the real-time clock register core
package rtc_pkg;
  // ==========================================================
  // widths and address map
  localparam int DATA_W = 8;
  localparam int ADDR_W = 8;
  localparam int IDX_W = 7;
  localparam int TIME_REGS = 7;
  localparam int ALARM_REGS = 8;
  localparam int ALARM_FIELDS = 4;
  localparam int RAM_BYTES = 96;
  localparam logic [7:0] WR_FLAG = 8'h80;
  localparam logic [6:0] ADDR_TIME_LAST = 7'h06;
  localparam logic [6:0] ADDR_ALARM_A_FIRST = 7'h07;
  localparam logic [6:0] ADDR_ALARM_A_LAST = 7'h0A;
  localparam logic [6:0] ADDR_ALARM_B_FIRST = 7'h0B;
  localparam logic [6:0] ADDR_ALARM_B_LAST = 7'h0E;
  localparam logic [6:0] ADDR_CONTROL = 7'h0F;
  localparam logic [6:0] ADDR_STATUS = 7'h10;
  localparam logic [6:0] ADDR_CHARGER = 7'h11;
  localparam logic [6:0] ADDR_RSVD_FIRST = 7'h12;
  localparam logic [6:0] ADDR_RSVD_LAST = 7'h1F;
  localparam logic [6:0] ADDR_RAM_FIRST = 7'h20;
  // ==========================================================
  // time register indices, write masks and reset values
  localparam int T_SEC = 0;
  localparam int T_MIN = 1;
  localparam int T_HR = 2;
  localparam int T_WDAY = 3;
  localparam int T_DATE = 4;
  localparam int T_MON = 5;
  localparam int T_YEAR = 6;
  localparam logic [7:0] TIME_WMASK [0:6] = '{8'h7F, 8'h7F, 8'h7F, 8'h07, 8'h3F, 8'h1F, 8'hFF};
  localparam logic [7:0] TIME_RESET [0:6] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01, 8'h00};
  localparam logic [7:0] ALARM_WMASK = 8'hFF;
  localparam logic [7:0] ALARM_DAY_WMASK = 8'h87;
  localparam logic [7:0] ALARM_RESET = 8'h00;
  localparam int ALARM_MASK_BIT = 7;
  localparam int HR_MODE_BIT = 6;
  localparam int HR_PM_BIT = 5;
  // ==========================================================
  // control and status fields
  localparam int CTL_HALT_BIT = 7;
  localparam int CTL_LOCK_BIT = 6;
  localparam int CTL_ROUTE_BIT = 2;
  localparam int CTL_EN_B_BIT = 1;
  localparam int CTL_EN_A_BIT = 0;
  localparam logic [7:0] CTL_WMASK = 8'hC7;
  localparam logic [7:0] CTL_RESET = 8'h80;
  localparam logic [7:0] CHARGER_RESET = 8'h5C;
  localparam logic [7:0] READ_ZERO = 8'h00;
  // ==========================================================
  // bcd limits of the calendar
  localparam logic [7:0] BCD_ZERO = 8'h00;
  localparam logic [7:0] SEC_LAST = 8'h59;
  localparam logic [7:0] MIN_LAST = 8'h59;
  localparam logic [5:0] HR24_LAST = 6'h23;
  localparam logic [5:0] HR24_FIRST = 6'h00;
  localparam logic [4:0] HR12_PRE = 5'h11;
  localparam logic [4:0] HR12_TOP = 5'h12;
  localparam logic [4:0] HR12_FIRST = 5'h01;
  localparam logic [7:0] WDAY_LAST = 8'h07;
  localparam logic [7:0] ONE_BCD = 8'h01;
  localparam logic [7:0] MONTH_LAST = 8'h12;
  localparam logic [7:0] YEAR_LAST = 8'h99;
  localparam logic [7:0] MON_FEB = 8'h02;
  localparam logic [7:0] MON_APR = 8'h04;
  localparam logic [7:0] MON_JUN = 8'h06;
  localparam logic [7:0] MON_SEP = 8'h09;
  localparam logic [7:0] MON_NOV = 8'h11;
  localparam logic [7:0] DIM_28 = 8'h28;
  localparam logic [7:0] DIM_29 = 8'h29;
  localparam logic [7:0] DIM_30 = 8'h30;
  localparam logic [7:0] DIM_31 = 8'h31;
  // ==========================================================
  // timebase: oscillator edges per second
  localparam int OSC_EDGES_PER_SEC = 32768;
endpackage

// ==== rtc_core.sv ====
// timekeeping, alarm and register core of a serial real-time clock
`timescale 1ns/100ps
module rtc_core #(
  parameter int OSC_EDGES = rtc_pkg::OSC_EDGES_PER_SEC
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic osc_clk,
  input wire logic xfer_start,
  input wire logic [rtc_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [rtc_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [rtc_pkg::DATA_W-1:0] reg_rdata,
  output logic irq_out_a_n,
  output logic irq_out_b_n
);
  import rtc_pkg::*;
  localparam int PW = $clog2(OSC_EDGES);
  localparam logic [PW-1:0] PRESCALE_LAST = PW'(OSC_EDGES - 1);
  localparam logic [PW-1:0] PRESCALE_ZERO = '0;
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    logic [7:0] r;
    r = (v[3:0] == 4'h9) ? {v[7:4] + 4'h1, 4'h0} : {v[7:4], v[3:0] + 4'h1};
    return r;
  endfunction
  // ==========================================================
  // storage
  logic [7:0] time_q [0:TIME_REGS-1];
  logic [7:0] snap_q [0:TIME_REGS-1];
  logic [7:0] alarm_q [0:ALARM_REGS-1];
  logic [7:0] ram_q [0:RAM_BYTES-1];
  logic [7:0] ctl_q;
  logic [7:0] charger_q;
  logic alarm_a_flag_q;
  logic alarm_b_flag_q;
  logic [7:0] rdata_q;
  logic irq_a_n_q;
  logic irq_b_n_q;
  logic [2:0] osc_s_q;
  logic osc_lvl_q;
  logic [PW-1:0] prescale_q;

  // ==========================================================
  // register port decode
  wire [6:0] ridx = reg_addr[6:0];
  wire is_write_addr = reg_addr[7];
  wire oscillator_halt = ctl_q[CTL_HALT_BIT];
  wire write_lock = ctl_q[CTL_LOCK_BIT];
  wire alarm_pin_routing = ctl_q[CTL_ROUTE_BIT];
  wire alarm_a_irq_enable = ctl_q[CTL_EN_A_BIT];
  wire alarm_b_irq_enable = ctl_q[CTL_EN_B_BIT];
  wire wr_any = reg_wr && is_write_addr;
  wire wr_ok = wr_any && !write_lock;
  wire wr_ctl = wr_any && ridx == ADDR_CONTROL;
  wire wr_sec = wr_ok && ridx == 7'(T_SEC);
  wire wr_ram = wr_ok && ridx >= ADDR_RAM_FIRST;
  wire [6:0] ram_idx = ridx - ADDR_RAM_FIRST;
  wire touch = reg_wr || reg_rd;
  wire touch_a = touch && ridx >= ADDR_ALARM_A_FIRST && ridx <= ADDR_ALARM_A_LAST;
  wire touch_b = touch && ridx >= ADDR_ALARM_B_FIRST && ridx <= ADDR_ALARM_B_LAST;

  // ==========================================================
  // oscillator input: three-stage sampler, change taken when the last two agree
  wire osc_agree = osc_s_q[1] == osc_s_q[2];
  wire osc_rise = osc_agree && osc_s_q[2] && !osc_lvl_q;
  wire sec_tick = osc_rise && !oscillator_halt && prescale_q == PRESCALE_LAST;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      osc_s_q <= 3'h0;
      osc_lvl_q <= 1'b0;
    end
    else
    begin
      osc_s_q <= {osc_s_q[1:0], osc_clk};
      osc_lvl_q <= osc_agree ? osc_s_q[2] : osc_lvl_q;
    end
  end
  // writing seconds restarts the divider so a fresh second follows
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prescale_q <= PRESCALE_ZERO;
    else if (wr_sec)
      prescale_q <= PRESCALE_ZERO;
    else if (osc_rise && !oscillator_halt)
      prescale_q <= (prescale_q == PRESCALE_LAST) ? PRESCALE_ZERO : prescale_q + 1'b1;
  end

  // ==========================================================
  // next calendar value, all fields bcd
  wire [7:0] hr_q = time_q[T_HR];
  wire [7:0] yr_q = time_q[T_YEAR];
  wire [7:0] mon_q = time_q[T_MON];
  wire [7:0] inc12 = bcd_inc({3'h0, hr_q[4:0]});
  wire [7:0] inc24 = bcd_inc({2'h0, hr_q[5:0]});
  wire leap = yr_q[4] ? (yr_q[3:0] == 4'h2 || yr_q[3:0] == 4'h6)
                      : (yr_q[3:0] == 4'h0 || yr_q[3:0] == 4'h4 || yr_q[3:0] == 4'h8);
  wire short30 = mon_q == MON_APR || mon_q == MON_JUN || mon_q == MON_SEP || mon_q == MON_NOV;
  wire [7:0] month_end = (mon_q == MON_FEB) ? (leap ? DIM_29 : DIM_28) : (short30 ? DIM_30 : DIM_31);
  logic [7:0] nxt [0:TIME_REGS-1];
  logic c_min;
  logic c_hr;
  logic c_day;
  logic c_mon;
  logic c_yr;
  always_comb
  begin
    nxt = time_q;
    c_min = time_q[T_SEC] == SEC_LAST;
    c_hr = c_min && time_q[T_MIN] == MIN_LAST;
    c_day = 1'b0;
    c_mon = 1'b0;
    c_yr = 1'b0;
    nxt[T_SEC] = c_min ? BCD_ZERO : bcd_inc(time_q[T_SEC]);
    if (c_min)
      nxt[T_MIN] = c_hr ? BCD_ZERO : bcd_inc(time_q[T_MIN]);
    if (c_hr)
    begin
      if (hr_q[HR_MODE_BIT])
      begin
        if (hr_q[4:0] == HR12_TOP)
          nxt[T_HR] = {hr_q[7:5], HR12_FIRST};
        else if (hr_q[4:0] == HR12_PRE)
        begin
          nxt[T_HR] = {hr_q[7:6], ~hr_q[HR_PM_BIT], HR12_TOP};
          c_day = hr_q[HR_PM_BIT];
        end
        else
          nxt[T_HR] = {hr_q[7:5], inc12[4:0]};
      end
      else if (hr_q[5:0] == HR24_LAST)
      begin
        nxt[T_HR] = {hr_q[7:6], HR24_FIRST};
        c_day = 1'b1;
      end
      else
        nxt[T_HR] = {hr_q[7:6], inc24[5:0]};
    end
    if (c_day)
    begin
      nxt[T_WDAY] = (time_q[T_WDAY] == WDAY_LAST) ? ONE_BCD : time_q[T_WDAY] + ONE_BCD;
      c_mon = time_q[T_DATE] == month_end;
      nxt[T_DATE] = c_mon ? ONE_BCD : bcd_inc(time_q[T_DATE]);
    end
    if (c_mon)
    begin
      c_yr = mon_q == MONTH_LAST;
      nxt[T_MON] = c_yr ? ONE_BCD : bcd_inc(mon_q);
    end
    if (c_yr)
      nxt[T_YEAR] = (yr_q == YEAR_LAST) ? BCD_ZERO : bcd_inc(yr_q);
  end

  // ==========================================================
  // time, alarm and ram registers; a host write beats the tick for its field
  genvar gi;
  generate
    for (gi = 0; gi < TIME_REGS; gi++)
    begin : g_time
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          time_q[gi] <= TIME_RESET[gi];
        else if (wr_ok && ridx == 7'(gi))
          time_q[gi] <= reg_wdata & TIME_WMASK[gi];
        else if (sec_tick)
          time_q[gi] <= nxt[gi];
      end
    end
    for (gi = 0; gi < ALARM_REGS; gi++)
    begin : g_alarm
      localparam logic [7:0] WM = (gi % ALARM_FIELDS == ALARM_FIELDS - 1) ? ALARM_DAY_WMASK : ALARM_WMASK;
      always_ff @(posedge mclk or posedge rst)
      begin
        if (rst)
          alarm_q[gi] <= ALARM_RESET;
        else if (wr_ok && ridx == ADDR_ALARM_A_FIRST + 7'(gi))
          alarm_q[gi] <= reg_wdata & WM;
      end
    end
  endgenerate
  // battery-backed contents are not cleared by reset
  always_ff @(posedge mclk)
  begin
    if (wr_ram)
      ram_q[ram_idx] <= reg_wdata;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      ctl_q <= CTL_RESET;
    else if (wr_ctl && write_lock)
      ctl_q[CTL_LOCK_BIT] <= reg_wdata[CTL_LOCK_BIT];
    else if (wr_ctl)
      ctl_q <= reg_wdata & CTL_WMASK;
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      charger_q <= CHARGER_RESET;
    else if (wr_ok && ridx == ADDR_CHARGER)
      charger_q <= reg_wdata;
  end
  // ==========================================================
  // snapshot: taken at each transaction start, then left alone
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      snap_q <= TIME_RESET;
    else if (xfer_start)
      snap_q <= time_q;
  end

  // ==========================================================
  // alarm match against the time that the tick is about to load
  logic [ALARM_FIELDS-1:0] hit_a;
  logic [ALARM_FIELDS-1:0] hit_b;
  generate
    for (gi = 0; gi < ALARM_FIELDS; gi++)
    begin : g_match
      assign hit_a[gi] = alarm_q[gi][ALARM_MASK_BIT] || alarm_q[gi][6:0] == nxt[gi][6:0];
      assign hit_b[gi] = alarm_q[gi + ALARM_FIELDS][ALARM_MASK_BIT]
                         || alarm_q[gi + ALARM_FIELDS][6:0] == nxt[gi][6:0];
    end
  endgenerate
  wire match_a = &hit_a;
  wire match_b = &hit_b;
  wire set_a = sec_tick && match_a;
  wire set_b = sec_tick && match_b;
  // a match in the same cycle as a clearing access still sets the flag
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      alarm_a_flag_q <= 1'b0;
      alarm_b_flag_q <= 1'b0;
    end
    else
    begin
      alarm_a_flag_q <= set_a || (alarm_a_flag_q && !touch_a);
      alarm_b_flag_q <= set_b || (alarm_b_flag_q && !touch_b);
    end
  end

  // ==========================================================
  // interrupt pins, active low
  wire req_a = alarm_a_flag_q && alarm_a_irq_enable;
  wire req_b = alarm_b_flag_q && alarm_b_irq_enable;
  wire pin_a = req_a || (!alarm_pin_routing && req_b);
  wire pin_b = alarm_pin_routing && req_b;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      irq_a_n_q <= 1'b1;
      irq_b_n_q <= 1'b1;
    end
    else
    begin
      irq_a_n_q <= !pin_a;
      irq_b_n_q <= !pin_b;
    end
  end

  // ==========================================================
  // read mux; a read in the start cycle sees the live time, the same value the snapshot takes
  wire [2:0] tidx = ridx[2:0];
  wire [2:0] aidx = 3'(ridx - ADDR_ALARM_A_FIRST);
  wire [7:0] time_view = xfer_start ? time_q[tidx] : snap_q[tidx];
  wire [7:0] status_view = {6'h00, alarm_b_flag_q, alarm_a_flag_q};
  wire [7:0] rd_val = (ridx <= ADDR_TIME_LAST) ? time_view
                    : (ridx <= ADDR_ALARM_B_LAST) ? alarm_q[aidx]
                    : (ridx == ADDR_CONTROL) ? ctl_q
                    : (ridx == ADDR_STATUS) ? status_view
                    : (ridx == ADDR_CHARGER) ? charger_q
                    : (ridx >= ADDR_RAM_FIRST) ? ram_q[ram_idx]
                    : READ_ZERO;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      rdata_q <= READ_ZERO;
    else
      rdata_q <= (reg_rd && !is_write_addr) ? rd_val : READ_ZERO;
  end
  assign reg_rdata = rdata_q;
  assign irq_out_a_n = irq_a_n_q;
  assign irq_out_b_n = irq_b_n_q;

  // ==========================================================
  // checks
  sequence s_tick_match_a;
    sec_tick && match_a;
  endsequence
  sequence s_quiet_a;
    !touch_a && !set_a;
  endsequence
  a_snap_take: assert property (@(posedge mclk) disable iff (rst)
    xfer_start |=> snap_q[T_SEC] == $past(time_q[T_SEC]))
    else $error("snapshot did not take the live seconds");
  a_snap_frozen: assert property (@(posedge mclk) disable iff (rst)
    !xfer_start [*3] |-> $stable(snap_q[T_MIN]) && $stable(snap_q[T_SEC]))
    else $error("snapshot moved without a new transaction");
  a_pm_toggle: assert property (@(posedge mclk) disable iff (rst)
    sec_tick && c_hr && !wr_ok && hr_q[HR_MODE_BIT] && hr_q[4:0] == HR12_PRE
    |=> time_q[T_HR][HR_PM_BIT] != $past(hr_q[HR_PM_BIT]) && time_q[T_HR][4:0] == HR12_TOP)
    else $error("pm bit did not toggle at twelve");
  a_hr24_wrap: assert property (@(posedge mclk) disable iff (rst)
    sec_tick && c_hr && !wr_ok && !hr_q[HR_MODE_BIT] && hr_q[5:0] == HR24_LAST
    |=> time_q[T_HR] == BCD_ZERO && time_q[T_WDAY] != $past(time_q[T_WDAY]))
    else $error("24-hour wrap did not reach midnight");
  a_flag_set: assert property (@(posedge mclk) disable iff (rst)
    s_tick_match_a |=> alarm_a_flag_q)
    else $error("first alarm flag not set");
  a_flag_hold: assert property (@(posedge mclk) disable iff (rst)
    s_tick_match_a ##1 s_quiet_a [*2] |=> alarm_a_flag_q)
    else $error("first alarm flag not held");
  a_flag_clear: assert property (@(posedge mclk) disable iff (rst)
    touch_b && !set_b |=> !alarm_b_flag_q)
    else $error("second alarm flag not cleared by access");
  a_shared_pin: assert property (@(posedge mclk) disable iff (rst)
    !alarm_pin_routing && req_b |=> !irq_out_a_n && irq_out_b_n)
    else $error("shared routing did not use the first pin");
  a_enable_gate: assert property (@(posedge mclk) disable iff (rst)
    !alarm_a_irq_enable && !(req_b && !alarm_pin_routing) |=> irq_out_a_n)
    else $error("first pin asserted while disabled");
  a_split_pin: assert property (@(posedge mclk) disable iff (rst)
    alarm_pin_routing && req_b && !req_a |=> !irq_out_b_n && irq_out_a_n)
    else $error("separate routing drove the wrong pin");
  a_halt_still: assert property (@(posedge mclk) disable iff (rst)
    oscillator_halt && !wr_any |=> $stable(time_q[T_SEC]) && $stable(prescale_q))
    else $error("time advanced while halted");
  a_lock_writes: assert property (@(posedge mclk) disable iff (rst)
    write_lock && reg_wr && ridx == ADDR_ALARM_A_FIRST |=> $stable(alarm_q[0]) && write_lock == $past(write_lock)
      || !write_lock)
    else $error("locked write changed a register");
  a_rsvd_zero: assert property (@(posedge mclk) disable iff (rst)
    reg_rd && !is_write_addr && ridx >= ADDR_RSVD_FIRST && ridx <= ADDR_RSVD_LAST |=> reg_rdata == READ_ZERO)
    else $error("reserved address read nonzero");
endmodule

// ==== host_bus.sv ====
// host side of the register port: byte accesses and transaction start strobe
`timescale 1ns/100ps
module host_bus (
  input wire logic mclk,
  input wire logic [rtc_pkg::DATA_W-1:0] rdata,
  output logic [rtc_pkg::ADDR_W-1:0] addr,
  output logic [rtc_pkg::DATA_W-1:0] wdata,
  output logic wr,
  output logic rd,
  output logic xfer
);
  import rtc_pkg::*;
  // ==========================================================
  // idle bus
  initial
  begin
    addr = 8'h00;
    wdata = 8'h00;
    wr = 1'b0;
    rd = 1'b0;
    xfer = 1'b0;
  end
  // ==========================================================
  // accesses; released lines show the inverse so stale values never look valid
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge mclk);
    addr <= a | WR_FLAG;
    wdata <= d;
    wr <= 1'b1;
    @(posedge mclk);
    wr <= 1'b0;
    addr <= ~a;
    wdata <= ~d;
  endtask
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge mclk);
    rd <= 1'b0;
    addr <= ~a;
    @(posedge mclk);
    d = rdata;
  endtask
  task automatic start();
    @(posedge mclk);
    xfer <= 1'b1;
    @(posedge mclk);
    xfer <= 1'b0;
  endtask
  // reset already clears the lock; this write clears it again, and sets halt only when the lock was not already set
  task automatic unlock();
    write(8'h0F, 8'h80);
  endtask
endmodule

// ==== rtc_core_test.sv ====
// self-checking bench of the real-time clock register core
`timescale 1ns/100ps
module rtc_core_test;
  import rtc_pkg::*;
  logic mclk;
  logic rst;
  logic osc_clk;
  logic xfer_start;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [7:0] reg_rdata;
  logic irq_out_a_n;
  logic irq_out_b_n;
  logic [7:0] d;
  int miscompares = 0;
  int n_checks = 0;
  // ==========================================================
  // clocks; the timebase is offset so its edges never meet mclk edges
  initial mclk = 1'b0;
  always #20 mclk = ~mclk;
  initial
  begin
    osc_clk = 1'b0;
    #13;
    forever #160 osc_clk = ~osc_clk;
  end
  // ==========================================================
  // design and host
  rtc_core #(.OSC_EDGES(4)) rtc_core_inst (
    .mclk(mclk), .rst(rst), .osc_clk(osc_clk), .xfer_start(xfer_start),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .irq_out_a_n(irq_out_a_n), .irq_out_b_n(irq_out_b_n)
  );
  host_bus host_bus_inst (
    .mclk(mclk), .rdata(reg_rdata), .addr(reg_addr), .wdata(reg_wdata),
    .wr(reg_wr), .rd(reg_rd), .xfer(xfer_start)
  );
  // ==========================================================
  // compare helpers
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
    host_bus_inst.read(a, d);
    chk(d, exp);
  endtask
  // pins follow flags one cycle late, so let two edges pass; e is {b_n, a_n}
  task automatic pins(input logic [1:0] e);
    repeat (2) @(posedge mclk);
    chk({6'h00, irq_out_b_n, irq_out_a_n}, {6'h00, e});
  endtask
  task automatic results();
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // ==========================================================
  // scenarios
  task automatic t_reset();
    rchk(8'h0F, 8'h80);
    rchk(8'h10, 8'h00);
    rchk(8'h12, 8'h00);
    rchk(8'h1F, 8'h00);
    host_bus_inst.start();
    rchk(8'h03, 8'h01);
    pins(2'b11);
  endtask
  task automatic t_lock();
    host_bus_inst.unlock();
    host_bus_inst.write(8'hA0, 8'h5A);
    host_bus_inst.write(8'h92, 8'hFF);
    rchk(8'h12, 8'h00);
    host_bus_inst.write(8'h0F, 8'h40);
    host_bus_inst.write(8'h07, 8'h55);
    host_bus_inst.write(8'hA0, 8'hA5);
    rchk(8'h07, 8'h00);
    rchk(8'h20, 8'h5A);
    rchk(8'h87, 8'h00);
    host_bus_inst.write(8'h0F, 8'h87);
    rchk(8'h0F, 8'h00);
    host_bus_inst.write(8'h0F, 8'hB8);
    rchk(8'h0F, 8'h80);
  endtask
  task automatic t_route();
    for (int i = 7; i <= 14; i++)
      host_bus_inst.write(i[7:0], 8'h80);
    host_bus_inst.write(8'h0F, 8'h04);
    repeat (45) @(posedge mclk);
    rchk(8'h10, 8'h03);
    pins(2'b11);
    host_bus_inst.write(8'h0F, 8'h05);
    pins(2'b10);
    host_bus_inst.write(8'h0F, 8'h06);
    pins(2'b01);
    host_bus_inst.write(8'h0F, 8'h02);
    pins(2'b10);
    host_bus_inst.write(8'h0F, 8'h82);
    host_bus_inst.read(8'h0C, d);
    pins(2'b11);
    rchk(8'h10, 8'h01);
    host_bus_inst.write(8'h8A, 8'h80);
    rchk(8'h10, 8'h00);
  endtask
  task automatic t_match();
    host_bus_inst.write(8'h0F, 8'h00);
    host_bus_inst.write(8'h88, 8'h80);
    host_bus_inst.write(8'h89, 8'h80);
    host_bus_inst.write(8'h87, 8'h02);
    host_bus_inst.write(8'h80, 8'h01);
    repeat (45) @(posedge mclk);
    host_bus_inst.read(8'h10, d);
    chk({7'h00, d[0]}, 8'h01);
    host_bus_inst.write(8'h87, 8'h03);
    host_bus_inst.write(8'h80, 8'h01);
    repeat (45) @(posedge mclk);
    host_bus_inst.read(8'h10, d);
    chk({7'h00, d[0]}, 8'h00);
  endtask
  // one second before a rollover; mid is high when the hour passes midnight
  task automatic t_roll(input logic [7:0] hr_in, input logic [7:0] hr_exp, input logic mid);
    logic [7:0] exp [0:6];
    exp = '{8'h00, 8'h00, hr_exp, 8'h01, 8'h01, 8'h03, 8'h23};
    if (!mid)
    begin
      exp[3] = 8'h07;
      exp[4] = 8'h28;
      exp[5] = 8'h02;
    end
    host_bus_inst.write(8'h81, 8'h59);
    host_bus_inst.write(8'h82, hr_in);
    host_bus_inst.write(8'h83, 8'h07);
    host_bus_inst.write(8'h84, 8'h28);
    host_bus_inst.write(8'h85, 8'h02);
    host_bus_inst.write(8'h86, 8'h23);
    host_bus_inst.write(8'h80, 8'h59);
    repeat (40) @(posedge mclk);
    host_bus_inst.start();
    for (int i = 0; i < 7; i++)
      rchk(i[7:0], exp[i]);
    repeat (12) @(posedge mclk);
    rchk(8'h00, 8'h00);
    host_bus_inst.start();
    rchk(8'h00, 8'h01);
  endtask
  // ==========================================================
  // main sequence
  initial
  begin
    rst = 1'b1;
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_reset();
    t_lock();
    t_route();
    t_match();
    t_roll(8'h71, 8'h52, 1'b1);
    t_roll(8'h51, 8'h72, 1'b0);
    t_roll(8'h19, 8'h20, 1'b0);
    t_roll(8'h23, 8'h00, 1'b1);
    results();
  end
endmodule
